// file: shared/gss_consts.svh
`ifndef GSS_CONSTS_SVH
`define GSS_CONSTS_SVH
// Register byte offsets
`define GSS_OFF_CTRL 12'h000
`define GSS_OFF_STAT 12'h004
`define GSS_OFF_FAIL 12'h008
`define GSS_OFF_CNT 12'h00C
// Control register fields and reset values
`define GSS_CTRL_CAP64 0
`define GSS_CTRL_PE1 1
`define GSS_CTRL_LIN_LO 8
`define GSS_CTRL_LIN_HI 14
`define GSS_RST_CAP64 1'b1
`define GSS_RST_PE1 1'b1
// Selector, access-rights and flag bit positions
`define GSS_SEL_TI 2
`define GSS_AR_S 4
`define GSS_AR_P 7
`define GSS_AR_L 13
`define GSS_AR_DB 14
`define GSS_AR_G 15
`define GSS_AR_UNUSE 16
`define GSS_FL_IF 9
`define GSS_FL_VM 17
// Fixed field values
`define GSS_V86_AR 32'h000000F3
`define GSS_V86_LIMIT 32'h0000FFFF
`define GSS_EVT_EXT 3'h0
// Failure vector bit positions
`define GSS_FB_SEL 0
`define GSS_FB_BASE 1
`define GSS_FB_LIMIT 2
`define GSS_FB_AR 3
`define GSS_FB_SYS 4
`define GSS_FB_DTR 5
`define GSS_FB_IP 6
`define GSS_FB_FLAGS 7
`endif

// file: shared/gss_pkg.sv
`default_nettype none
package gss_pkg;
   // One segment register image
   typedef struct packed {
      logic [15:0] sel;
      logic [63:0] base;
      logic [31:0] limit;
      logic [31:0] ar;
   } gss_seg_t;
   // Descriptor-table register image
   typedef struct packed {
      logic [63:0] base;
      logic [31:0] limit;
   } gss_dtr_t;
   // Guest fields and entry controls from the entry sequencer
   typedef struct packed {
      gss_seg_t [5:0] segs;
      gss_seg_t tr;
      gss_seg_t local_table_seg_field;
      gss_dtr_t global_table_field;
      gss_dtr_t vector_table_field;
      logic [63:0] instruction_pointer;
      logic [63:0] flags;
      logic pe;
      logic ia32e;
      logic ug;
      logic prim31;
      logic evt_valid;
      logic [2:0] evt_type;
   } gss_guest_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } gss_apb_req_t;
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } gss_apb_rsp_t;
   // Whole state of the checker
   typedef struct packed {
      logic cap64;
      logic pe1;
      logic [6:0] lin;
      logic done;
      logic fail;
      logic [7:0] fvec;
      logic [15:0] cnt;
      logic [31:0] prdata;
      logic pslverr;
   } gss_state_t;
endpackage
`default_nettype wire

// file: hdl/gss_checker.sv
// What this block does
// - Guest is virtual-8086 exactly when flags bit 17 is set.
// - A segment is usable only when access-rights bit 16 is clear.
// - Fail if task-state selector bit 2 set, or usable local-table bit 2.
// - Non-v86 without unrestricted: stack selector low bits equal code's.
// - In v86 each of six bases equals selector times sixteen.
// - On 64-bit parts: canonical or upper-zero base checks per segment.
// - In v86 all six access rights are F3 and limits FFFF.
// - Non-v86 code type 9/11/13/15; type 3 too with unrestricted.
// - Usable non-v86 stack segment type must be 3 or 7.
// - Usable data segment: accessed bit set; code type needs readable.
// - Code or usable segment: bits 4,7 set, 11:8 and 31:17 zero.
// - Code privilege: type 3 needs 0; 9/11 equal, 13/15 not above stack's.
// - Without unrestricted, stack privilege equals its selector level; zero for code type 3 or PE clear.
// - Usable data type 0..11 without unrestricted: privilege not below selector level.
// - Without both controls, code type not 3 and PE forced per capability.
// - 64-bit guest with code bit 13 set needs code bit 14 clear.
// - Granularity must agree with limit low and high bits.
// - Task-state type, system, present, usable and reserved bit checks.
// - Usable local-table: type 2, bit 4 clear, bit 7 set, reserved zero.
// - Table limits upper half zero; bases canonical on 64-bit parts.
// - On 64-bit parts: instruction pointer upper half zero, or canonical in 64-bit code.
// - Flags reserved bits zero and bit 1 set.
// - v86 flag clear for 64-bit guest or PE clear; IF for external event.
// - Checks run in any order concurrently; one verdict per request.
`include "gss_consts.svh"
`default_nettype none
module gss_checker #(
   parameter int LIN_BITS = 48
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire gss_pkg::gss_apb_req_t apb_req,
   output gss_pkg::gss_apb_rsp_t apb_rsp,
   input wire logic check_req,
   input wire gss_pkg::gss_guest_t guest,
   output logic check_done,
   output logic check_fail
);
   import gss_pkg::*;

   // Refuse widths that the canonical test cannot serve, at elaboration
   if (LIN_BITS < 33 || LIN_BITS > 64) begin : g_bad_lin
      $error("LIN_BITS must lie in 33..64");
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Bits n-1 upward all equal bit 63; n=64 always passes
   function automatic logic canon(input logic [63:0] a, input logic [6:0] n);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 64; i++) begin
         if (i >= int'(n) - 1 && a[i] != a[63]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // Granularity must match what the limit can express
   function automatic logic gran_bad(input logic [31:0] lim, input logic g);
      return (lim[11:0] != 12'hFFF && g) || (lim[31:20] != 12'h000 && !g);
   endfunction

   gss_state_t q, d;
   logic v86, ug, cap64;
   logic [6:0] lin;
   logic [5:0] v86_bad, base_bad, ar_bad, type_bad, dpl_bad;
   logic [3:0] cs_t, ss_t, tr_t, ld_t;
   logic [1:0] cs_dpl, ss_dpl;
   logic cs_ar_l, ld_use;
   logic sel_bad, sys_bad, dtr_bad, ip_bad, fl_bad, cs_bad;
   logic [7:0] fvec;

   assign v86 = guest.flags[`GSS_FL_VM];
   // Unrestricted counts only with the primary control bit set
   assign ug = guest.ug & guest.prim31;
   assign cap64 = q.cap64;
   assign lin = q.lin;
   assign cs_t = guest.segs[0].ar[3:0];
   assign ss_t = guest.segs[1].ar[3:0];
   assign tr_t = guest.tr.ar[3:0];
   assign ld_t = guest.local_table_seg_field.ar[3:0];
   assign cs_dpl = guest.segs[0].ar[6:5];
   assign ss_dpl = guest.segs[1].ar[6:5];
   assign cs_ar_l = guest.segs[0].ar[`GSS_AR_L];
   assign ld_use = ~guest.local_table_seg_field.ar[`GSS_AR_UNUSE];

   // ----------------------------------------
   // Per-segment checks: 0 code, 1 stack, 2..5 data
   // ----------------------------------------
   for (genvar i = 0; i < 6; i++) begin : g_seg
      gss_seg_t s;
      logic use_s, chk;
      assign s = guest.segs[i];
      assign use_s = ~s.ar[`GSS_AR_UNUSE];
      assign chk = (i == 0) | use_s;
      // Real-address style image of every segment
      assign v86_bad[i] = v86 & ((s.base != {44'h0, s.sel, 4'h0})
         | (s.limit != `GSS_V86_LIMIT) | (s.ar != `GSS_V86_AR));
      // Code, stack and first two data take upper zero; the rest canonical
      assign base_bad[i] = cap64 & ((i < 4) ? (chk & (s.base[63:32] != 32'h0))
         : !canon(s.base, lin));
      assign ar_bad[i] = chk & (!s.ar[`GSS_AR_S] | !s.ar[`GSS_AR_P]
         | (s.ar[11:8] != 4'h0) | (s.ar[31:17] != 15'h0)
         | gran_bad(s.limit, s.ar[`GSS_AR_G]));
      if (i == 0) begin : g_cs
         assign type_bad[i] = !v86 & !((s.ar[3:0] == 4'h9) | (s.ar[3:0] == 4'hB)
            | (s.ar[3:0] == 4'hD) | (s.ar[3:0] == 4'hF) | (ug & s.ar[3:0] == 4'h3));
         assign dpl_bad[i] = 1'b0;
      end else if (i == 1) begin : g_ss
         assign type_bad[i] = !v86 & use_s
            & !((s.ar[3:0] == 4'h3) | (s.ar[3:0] == 4'h7));
         assign dpl_bad[i] = 1'b0;
      end else begin : g_ds
         assign type_bad[i] = !v86 & use_s
            & (!s.ar[0] | (s.ar[3] & !s.ar[1]));
         // Lower privilege number than requested is refused for data
         assign dpl_bad[i] = !v86 & !ug & use_s & (s.ar[3:0] <= 4'hB)
            & (s.ar[6:5] < s.sel[1:0]);
      end
   end

   // ----------------------------------------
   // Code/stack pair, system segments, tables, pointer and flags
   // ----------------------------------------
   always_comb begin
      // Selector consistency
      sel_bad = guest.tr.sel[`GSS_SEL_TI]
         | (ld_use & guest.local_table_seg_field.sel[`GSS_SEL_TI])
         | (!v86 & !ug & (guest.segs[1].sel[1:0] != guest.segs[0].sel[1:0]));
      // Privilege relations of code and stack
      cs_bad = 1'b0;
      if (!v86) begin
         if (cs_t == 4'h3 && cs_dpl != 2'h0) begin
            cs_bad = 1'b1;
         end
         if ((cs_t == 4'h9 || cs_t == 4'hB) && cs_dpl != ss_dpl) begin
            cs_bad = 1'b1;
         end
         if ((cs_t == 4'hD || cs_t == 4'hF) && cs_dpl > ss_dpl) begin
            cs_bad = 1'b1;
         end
         if (!ug && ss_dpl != guest.segs[1].sel[1:0]) begin
            cs_bad = 1'b1;
         end
         if ((cs_t == 4'h3 || !guest.pe) && ss_dpl != 2'h0) begin
            cs_bad = 1'b1;
         end
      end
      if (!ug && (cs_t == 4'h3 || (q.pe1 && !guest.pe))) begin
         cs_bad = 1'b1;
      end
      if (guest.ia32e && cs_ar_l && guest.segs[0].ar[`GSS_AR_DB]) begin
         cs_bad = 1'b1;
      end
      // Task-state segment is always checked; local table only when usable
      sys_bad = (guest.ia32e ? (tr_t != 4'hB) : !(tr_t == 4'h3 || tr_t == 4'hB))
         | guest.tr.ar[`GSS_AR_S] | !guest.tr.ar[`GSS_AR_P]
         | (guest.tr.ar[11:8] != 4'h0) | guest.tr.ar[`GSS_AR_UNUSE]
         | (guest.tr.ar[31:17] != 15'h0)
         | gran_bad(guest.tr.limit, guest.tr.ar[`GSS_AR_G])
         | (cap64 & !canon(guest.tr.base, lin));
      if (ld_use) begin
         sys_bad = sys_bad | (ld_t != 4'h2) | guest.local_table_seg_field.ar[`GSS_AR_S]
            | !guest.local_table_seg_field.ar[`GSS_AR_P] | (guest.local_table_seg_field.ar[11:8] != 4'h0)
            | (guest.local_table_seg_field.ar[31:17] != 15'h0)
            | gran_bad(guest.local_table_seg_field.limit, guest.local_table_seg_field.ar[`GSS_AR_G])
            | (cap64 & !canon(guest.local_table_seg_field.base, lin));
      end
      dtr_bad = (guest.global_table_field.limit[31:16] != 16'h0)
         | (guest.vector_table_field.limit[31:16] != 16'h0)
         | (cap64 & (!canon(guest.global_table_field.base, lin) | !canon(guest.vector_table_field.base, lin)));
      // Wide pointer only in 64-bit code; otherwise upper half zero
      ip_bad = 1'b0;
      if (cap64) begin
         if (guest.ia32e && cs_ar_l) begin
            // Only bits N upward must agree here, one bit fewer than a base needs
            ip_bad = !canon(guest.instruction_pointer, lin + 7'd1);
         end else begin
            ip_bad = guest.instruction_pointer[63:32] != 32'h0;
         end
      end
      fl_bad = guest.flags[15] | guest.flags[5] | guest.flags[3]
         | !guest.flags[1] | (guest.flags[31:22] != 10'h0)
         | (cap64 & (guest.flags[63:32] != 32'h0))
         | (v86 & (guest.ia32e | !guest.pe))
         | (guest.evt_valid & guest.evt_type == `GSS_EVT_EXT
            & !guest.flags[`GSS_FL_IF]);
      // Failure categories, all evaluated together
      fvec = 8'h00;
      fvec[`GSS_FB_SEL] = sel_bad;
      fvec[`GSS_FB_BASE] = |(v86_bad | base_bad);
      fvec[`GSS_FB_LIMIT] = |v86_bad;
      fvec[`GSS_FB_AR] = |(ar_bad | type_bad | dpl_bad) | cs_bad;
      fvec[`GSS_FB_SYS] = sys_bad;
      fvec[`GSS_FB_DTR] = dtr_bad;
      fvec[`GSS_FB_IP] = ip_bad;
      fvec[`GSS_FB_FLAGS] = fl_bad;
   end

   // ----------------------------------------
   // Verdict and register file
   // ----------------------------------------
   // Read data is latched in the setup phase so it stands through the access
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (check_req) begin
         d.done = 1'b1;
         d.fvec = fvec;
         d.fail = |fvec;
         d.cnt = q.cnt + 16'h0001;
      end
      if (apb_req.psel && !apb_req.penable) begin
         d.prdata = 32'h0;
         d.pslverr = 1'b0;
         case (apb_req.paddr)
            `GSS_OFF_CTRL: begin
               d.prdata[`GSS_CTRL_CAP64] = q.cap64;
               d.prdata[`GSS_CTRL_PE1] = q.pe1;
               d.prdata[`GSS_CTRL_LIN_HI:`GSS_CTRL_LIN_LO] = q.lin;
            end
            `GSS_OFF_STAT: d.prdata[1:0] = {q.done, q.fail};
            `GSS_OFF_FAIL: d.prdata[7:0] = q.fvec;
            `GSS_OFF_CNT: d.prdata[15:0] = q.cnt;
            default: d.pslverr = 1'b1;
         endcase
      end
      // Writes land only at the access edge; only control is writable
      if (apb_req.psel && apb_req.penable && apb_req.pwrite
          && apb_req.paddr == `GSS_OFF_CTRL) begin
         d.cap64 = apb_req.pwdata[`GSS_CTRL_CAP64];
         d.pe1 = apb_req.pwdata[`GSS_CTRL_PE1];
         // Widths the canonical test cannot serve keep the old value
         if (apb_req.pwdata[`GSS_CTRL_LIN_HI:`GSS_CTRL_LIN_LO] >= 7'd33
             && apb_req.pwdata[`GSS_CTRL_LIN_HI:`GSS_CTRL_LIN_LO] <= 7'd64) begin
            d.lin = apb_req.pwdata[`GSS_CTRL_LIN_HI:`GSS_CTRL_LIN_LO];
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.cap64 <= `GSS_RST_CAP64;
         q.pe1 <= `GSS_RST_PE1;
         q.lin <= 7'(LIN_BITS);
      end else begin
         q <= d;
      end
   end

   assign apb_rsp.pready = 1'b1; // Zero wait states
   assign apb_rsp.prdata = q.prdata;
   assign apb_rsp.pslverr = q.pslverr & apb_req.psel & apb_req.penable;
   assign check_done = q.done;
   assign check_fail = q.fail;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_done_after_req: assert property (@(posedge pclk) disable iff (!presetn)
      check_req |=> check_done ##1 (check_done == $past(check_req)))
      else $error("verdict not one cycle after request");
   a_fail_is_or: assert property (@(posedge pclk) disable iff (!presetn)
      check_done |-> (check_fail == (q.fvec != 8'h00)))
      else $error("fail differs from failure vector");
   a_tr_ti_fails: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && guest.tr.sel[2]) |=> (check_fail && q.fvec[0]))
      else $error("task-state table bit accepted");
   a_ss_rpl_match: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && !v86 && !ug && guest.segs[1].sel[1:0] != guest.segs[0].sel[1:0])
      |=> q.fvec[0])
      else $error("stack level mismatch accepted");
   a_v86_limit_bad: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && v86 && guest.segs[3].limit != 32'h0000FFFF) |=> q.fvec[2])
      else $error("v86 limit mismatch accepted");
   a_cs_type3_bad: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && !guest.prim31 && cs_t == 4'h3) |=> check_fail)
      else $error("code type 3 accepted without controls");
   a_gdt_limit_hi: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && guest.global_table_field.limit[31:16] != 16'h0) |=> q.fvec[5])
      else $error("table limit upper bits accepted");
   a_flag_bit1: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && !guest.flags[1]) |=> (check_fail && q.fvec[7]))
      else $error("flags bit 1 clear accepted");
   a_if_ext_evt: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && guest.evt_valid && guest.evt_type == 3'h0 && !guest.flags[9])
      |=> q.fvec[7])
      else $error("external event with IF clear accepted");
   a_ldt_ti_fails: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && ld_use && guest.local_table_seg_field.sel[2]) |=> q.fvec[0])
      else $error("local table bit accepted");
   a_cs_db_long: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && guest.ia32e && cs_ar_l && guest.segs[0].ar[14]) |=> q.fvec[3])
      else $error("long code with default size accepted");
   a_ip_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && cap64 && !guest.ia32e && guest.instruction_pointer[63:32] != 32'h0) |=> q.fvec[6])
      else $error("pointer upper half accepted");
   a_v86_base_img: assert property (@(posedge pclk) disable iff (!presetn)
      (check_req && v86
         && guest.segs[2].base != {44'h0, guest.segs[2].sel, 4'h0}) |=> q.fvec[1])
      else $error("v86 base image accepted");
endmodule
`default_nettype wire

// file: sim/gss_seq_model.sv
`default_nettype none
module gss_seq_model (
   input wire logic pclk,
   output logic check_req,
   output gss_pkg::gss_guest_t guest,
   input wire logic check_done,
   input wire logic check_fail
);
   timeunit 1ns;
   timeprecision 1ns;
   import gss_pkg::*;

   // Idle at time zero: no request, fields hold nothing meaningful
   initial begin
      check_req = 1'b0;
      guest = '0;
   end

   // One entry request; fields are only valid at the taking edge, so they
   // are scrambled right after it to catch a checker that samples late
   task automatic run(input gss_guest_t g, output logic fail, output logic late);
      @(posedge pclk);
      check_req <= 1'b1;
      guest <= g;
      @(posedge pclk);
      check_req <= 1'b0;
      guest <= ~g;
      // The done pulse stands between the two edges after the request
      @(negedge pclk);
      late = (check_done !== 1'b1);
      fail = check_fail;
   endtask
endmodule
`default_nettype wire

// file: sim/test_gss_checker.sv
`include "gss_consts.svh"
`default_nettype none
module test_gss_checker;
   timeunit 1ns;
   timeprecision 1ns;
   import gss_pkg::*;
   logic pclk;
   logic presetn;
   gss_apb_req_t req;
   gss_apb_rsp_t rsp;
   logic check_req;
   logic check_done;
   logic check_fail;
   gss_guest_t guest;
   gss_guest_t g;
   gss_guest_t gb;
   gss_guest_t gv;
   logic [15:0] s;
   logic [31:0] rd;
   logic er;
   int error_cnt;
   int checks_done;
   int n_req;

   gss_checker #(.LIN_BITS(48)) gss_checker_inst (
      .pclk(pclk),
      .presetn(presetn),
      .apb_req(req),
      .apb_rsp(rsp),
      .check_req(check_req),
      .guest(guest),
      .check_done(check_done),
      .check_fail(check_fail)
   );

   gss_seq_model gss_seq_model_inst (
      .pclk(pclk),
      .check_req(check_req),
      .guest(guest),
      .check_done(check_done),
      .check_fail(check_fail)
   );

   // 10 MHz clock
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   // ----------------------------------------
   // Compare, bus and verdict tasks
   // ----------------------------------------
   task automatic cmp_bit(input string n, input logic e, input logic v);
      checks_done++;
      if (v !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", n, e, v);
      end
   endtask

   task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] v);
      checks_done++;
      if (v !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, v);
      end
   endtask

   // APB transfer; waits for pready, the watchdog ends a stuck slave
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      cmp_bit("pready", 1'b1, rsp.pready);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // Runs guest g, checks verdict timing and failure categories, then resets g to gb
   task automatic chk(input logic fe, input logic [7:0] m);
      logic f;
      logic late;
      gss_seq_model_inst.run(g, f, late);
      n_req++;
      cmp_bit("done_late", 1'b0, late);
      cmp_bit("verdict", fe, f);
      apb(1'b0, `GSS_OFF_FAIL, 32'h0);
      cmp_word("fail_vec", fe ? {24'h0, m} : 32'h0, fe ? (rd & {24'h0, m}) : rd);
      g = gb;
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      give_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      req = '0;
      error_cnt = 0;
      checks_done = 0;
      n_req = 0;
      // Consistent flat protected-mode guest
      gb = '0;
      gb.segs[0] = '{16'h0008, 64'h0, 32'hFFFF_FFFF, 32'h0000_C09B};
      for (int i = 1; i < 6; i++)
         gb.segs[i] = '{16'h0010, 64'h0, 32'hFFFF_FFFF, 32'h0000_C093};
      gb.tr = '{16'h0028, 64'h0, 32'h0000_0067, 32'h0000_008B};
      gb.local_table_seg_field.ar = 32'h0001_0000;
      gb.global_table_field.limit = 32'h0000_00FF;
      gb.vector_table_field.limit = 32'h0000_0FFF;
      gb.instruction_pointer = 64'h1000;
      gb.flags = 64'h2;
      gb.pe = 1'b1;
      // Consistent virtual-8086 guest; base is selector times sixteen
      gv = gb;
      gv.flags = 64'h0002_0002;
      {gv.ug, gv.prim31} = 2'b11;
      for (int i = 0; i < 6; i++) begin
         s = 16'h0100 + 16'(i);
         gv.segs[i] = '{s, {44'h0, s, 4'h0}, 32'h0000_FFFF, 32'h0000_00F3};
      end
      g = gb;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `GSS_OFF_CTRL, 32'h0);
      cmp_word("ctrl_rst", 32'h0000_3003, rd);
      cmp_bit("slverr", 1'b0, er);
      apb(1'b0, 12'h010, 32'h0);
      cmp_bit("slverr_unmapped", 1'b1, er);
      cmp_word("unmapped", 32'h0, rd);
      chk(1'b0, 8'h00);
      g.tr.sel[2] = 1'b1;
      chk(1'b1, 8'h01);
      g.local_table_seg_field.sel[2] = 1'b1;
      chk(1'b0, 8'h00);
      g.local_table_seg_field.ar = 32'h0000_0082;
      chk(1'b0, 8'h00);
      g.local_table_seg_field.ar = 32'h0000_0082;
      g.local_table_seg_field.sel[2] = 1'b1;
      chk(1'b1, 8'h01);
      g.local_table_seg_field.ar = 32'h0000_0083;
      chk(1'b1, 8'h10);
      g.segs[0].sel = 16'h000B;
      chk(1'b1, 8'h01);
      g.flags[3] = 1'b1;
      chk(1'b1, 8'h80);
      g.flags[1] = 1'b0;
      chk(1'b1, 8'h80);
      g.flags[40] = 1'b1;
      chk(1'b1, 8'h80);
      g.segs[0].ar[3:0] = 4'h3;
      chk(1'b1, 8'h08);
      {g.ug, g.prim31} = 2'b11;
      g.segs[0].ar[3:0] = 4'h3;
      chk(1'b0, 8'h00);
      {g.ug, g.prim31} = 2'b10;
      g.segs[0].ar[3:0] = 4'h3;
      chk(1'b1, 8'h08);
      g.pe = 1'b0;
      chk(1'b1, 8'h08);
      g.segs[1].ar[3:0] = 4'h5;
      chk(1'b1, 8'h08);
      g.segs[2].ar[0] = 1'b0;
      chk(1'b1, 8'h08);
      g.segs[3].ar[3:0] = 4'h9;
      chk(1'b1, 8'h08);
      g.segs[2].ar = 32'h0001_0000;
      chk(1'b0, 8'h00);
      g.segs[0].ar[9] = 1'b1;
      chk(1'b1, 8'h08);
      g.segs[4].ar[4] = 1'b0;
      chk(1'b1, 8'h08);
      g.segs[0].limit = 32'h0000_0FFE;
      chk(1'b1, 8'h08);
      g.segs[0].ar[6:5] = 2'h1;
      chk(1'b1, 8'h08);
      g.segs[0].ar[3:0] = 4'hF;
      chk(1'b0, 8'h00);
      g.segs[1].ar[6:5] = 2'h3;
      chk(1'b1, 8'h08);
      g.segs[3].sel[1:0] = 2'h3;
      chk(1'b1, 8'h08);
      g.ia32e = 1'b1;
      g.segs[0].ar[13] = 1'b1;
      chk(1'b1, 8'h08);
      g.tr.ar[3:0] = 4'h9;
      chk(1'b1, 8'h10);
      g.ia32e = 1'b1;
      g.tr.ar[3:0] = 4'h3;
      chk(1'b1, 8'h10);
      g.tr.ar[16] = 1'b1;
      chk(1'b1, 8'h10);
      g.tr.limit = 32'h0010_0067;
      chk(1'b1, 8'h10);
      g.global_table_field.limit = 32'h0001_0000;
      chk(1'b1, 8'h20);
      g.vector_table_field.base = 64'h0000_8000_0000_0000;
      chk(1'b1, 8'h20);
      g.instruction_pointer = 64'h1_0000_0000;
      chk(1'b1, 8'h40);
      // Bit N-1 may differ from the bits above it in the pointer
      g.ia32e = 1'b1;
      g.segs[0].ar = 32'h0000_A09B;
      g.instruction_pointer = 64'h0000_8000_0000_0000;
      chk(1'b0, 8'h00);
      g.ia32e = 1'b1;
      g.segs[0].ar = 32'h0000_A09B;
      g.instruction_pointer = 64'h0001_0000_0000_0000;
      chk(1'b1, 8'h40);
      g.segs[0].base[32] = 1'b1;
      chk(1'b1, 8'h02);
      g.segs[2].base[40] = 1'b1;
      chk(1'b1, 8'h02);
      g.segs[4].base[50] = 1'b1;
      chk(1'b1, 8'h02);
      // System segment bases report in the system category
      g.tr.base[50] = 1'b1;
      chk(1'b1, 8'h10);
      g.local_table_seg_field.ar = 32'h0000_0082;
      g.local_table_seg_field.base[50] = 1'b1;
      chk(1'b1, 8'h10);
      g.segs[5].base = 64'hFFFF_8000_0000_0000;
      chk(1'b0, 8'h00);
      g.evt_valid = 1'b1;
      chk(1'b1, 8'h80);
      g.evt_valid = 1'b1;
      g.flags[9] = 1'b1;
      chk(1'b0, 8'h00);
      g.flags[17] = 1'b1;
      chk(1'b1, 8'h06);
      g = gv;
      chk(1'b0, 8'h00);
      g = gv;
      g.segs[4].base[4] = 1'b1;
      chk(1'b1, 8'h02);
      g = gv;
      g.segs[1].limit = 32'h0000_FFFE;
      chk(1'b1, 8'h04);
      g = gv;
      g.segs[5].ar = 32'h0000_00F2;
      chk(1'b1, 8'h04);
      g = gv;
      g.ia32e = 1'b1;
      chk(1'b1, 8'h80);
      apb(1'b0, `GSS_OFF_STAT, 32'h0);
      cmp_bit("stat_fail", 1'b1, rd[0]);
      // Control register: capability bits and linear width
      apb(1'b1, `GSS_OFF_CTRL, 32'h0000_3001);
      g.pe = 1'b0;
      chk(1'b0, 8'h00);
      apb(1'b1, `GSS_OFF_CTRL, 32'h0000_3000);
      g.segs[0].base[32] = 1'b1;
      chk(1'b0, 8'h00);
      g.flags[40] = 1'b1;
      chk(1'b0, 8'h00);
      g.flags[30] = 1'b1;
      chk(1'b1, 8'h80);
      apb(1'b1, `GSS_OFF_CTRL, 32'h0000_4003);
      g.vector_table_field.base[47] = 1'b1;
      chk(1'b0, 8'h00);
      apb(1'b1, `GSS_OFF_CTRL, 32'h0000_4603);
      apb(1'b0, `GSS_OFF_CTRL, 32'h0);
      cmp_word("ctrl_lin", 32'h0000_4003, rd);
      apb(1'b0, `GSS_OFF_CNT, 32'h0);
      cmp_word("req_count", {16'h0, n_req[15:0]}, {16'h0, rd[15:0]});
      give_verdict();
   end
endmodule
`default_nettype wire
